/* File: src/wtt_pkg.sv */
// constants for the watchpoint trace trigger block
// assumes a 32-bit apb slave on one clock, synchronous reset
package wtt_pkg;
   localparam logic [11:0] OFF_FCT0    = 12'h028;
   localparam logic [11:0] OFF_FCT1    = 12'h038;
   localparam logic [11:0] OFF_TBCTRL  = 12'h200;
   localparam logic [11:0] OFF_CMP0    = 12'h300;
   localparam logic [11:0] OFF_IRQSTAT = 12'h304;
   localparam logic [11:0] OFF_IRQCLR  = 12'h308;
   localparam logic [11:0] OFF_IRQEN   = 12'h30c;
   localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
   localparam logic [3:0]  NUM_COMP    = 4'h2;
   localparam int          MATCH_BIT   = 24;
   localparam int          DVADDR_BIT  = 12;
   localparam int          DVMATCH_BIT = 8;
   localparam int          CNT_LSB     = 28;
   localparam logic [3:0]  FN_OFF      = 4'h0;
   localparam logic [3:0]  FN_FETCH    = 4'h4;
   localparam logic [3:0]  FN_RD       = 4'h5;
   localparam logic [3:0]  FN_WR       = 4'h6;
   localparam logic [3:0]  FN_RW       = 4'h7;
endpackage : wtt_pkg

/* File: src/wtt_trigger.sv */
// watchpoint comparator function, match flags and trace trigger control
// assumes an apb master on core_clk and per-comparator hit inputs from
// the comparators (address hits already masked, data hit from comparator 0)

// How it works
// - comparator 1 data fields read zero, ignore writes
// - match flag set when selected operation occurs
// - reading function register clears its match flag
// - action field selects disabled, fetch, read, write, read or write
// - masked comparator 1 address gives linked range
// - start wins when start and stop coincide
// - recorder obeys requests only when enabled
// - comparator count field reads two
// - comp1_action picks stop or start
// - comp0_action zero issues trace stop
// - address match on comparator 0 when data disabled
// - data match alone when not linked
// - linked mode needs data and address together
// - reserved bits always read zero
// - data enable picks address or data compare
module wtt_trigger (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        busFetch,
   input  wire logic        busRead,
   input  wire logic        busWrite,
   input  wire logic        addrHit0,
   input  wire logic        dataHit0,
   input  wire logic        addrHit1,
   input  wire logic        startTriggerEnable,
   input  wire logic        stopTriggerEnable,
   output logic             traceStartPulse,
   output logic             traceStopPulse,
   output logic             traceRecording,
   output logic             irq
);
   // comparator function fields
   logic [3:0]  fn0_q;
   logic [3:0]  fn1_q;
   logic        dvMatch_q;
   logic        dvAddr_q;
   // sticky match flags, cleared by a read of their register
   logic        match0_q;
   logic        match1_q;
   // per-comparator choice of start or stop request
   logic        act0_q;
   logic        act1_q;
   // recorder state as seen inside the block
   logic        recording_q;
   // interrupt status and enable, one bit per event
   logic [3:0]  irqStat_q;
   logic [3:0]  irqEn_q;
   logic [3:0]  irqSet;
   logic [3:0]  irqClr;
   // qualified comparator hits of this cycle
   logic        hit0;
   logic        hit1;
   // flag rises and the requests they raise
   logic        rise0;
   logic        rise1;
   logic        req0Start;
   logic        req0Stop;
   logic        req1Start;
   logic        req1Stop;
   logic        start_d;
   logic        stop_d;
   // apb phase decode
   logic        setup;
   logic        wrAcc;
   logic        rdAcc;
   // read word assembled during the setup cycle
   logic [31:0] rdWord;
   logic        rdErr;

   // fixed one-wait-free apb: answer in the access phase
   assign setup = psel & ~penable;
   assign wrAcc = psel & penable & pwrite;
   assign rdAcc = psel & penable & ~pwrite;

   function automatic logic opHit(input logic [3:0] fn);
      case (fn)
         wtt_pkg::FN_FETCH: opHit = busFetch;
         wtt_pkg::FN_RD:    opHit = busRead;
         wtt_pkg::FN_WR:    opHit = busWrite;
         wtt_pkg::FN_RW:    opHit = busRead | busWrite;
         default:           opHit = 1'b0;
      endcase
   endfunction : opHit

   // write access to one register offset
   function automatic logic wrTo(input logic [11:0] a);
      wrTo = wrAcc && (paddr == a);
   endfunction : wrTo

   // read access to one register offset
   function automatic logic rdFrom(input logic [11:0] a);
      rdFrom = rdAcc && (paddr == a);
   endfunction : rdFrom

   always_comb begin
      if (!dvMatch_q) begin
         hit0 = addrHit0 & opHit(fn0_q);
      // linked data plus address, range via masked hit
      end else if (dvAddr_q) begin
         hit0 = dataHit0 & addrHit1 & opHit(fn0_q);
      end else begin
         hit0 = dataHit0 & opHit(fn0_q);
      end
      // addrHit1 also feeds comp 0 in linked use; comparator 1 keeps its own hit
      hit1 = addrHit1 & opHit(fn1_q);
   end

   // comparator 0 sticky flag, cleared by a read
   // a hit in the clearing cycle wins so no match is lost
   always_ff @(posedge core_clk) begin
      if (rst)
         match0_q <= 1'b0;
      else if (hit0)
         match0_q <= 1'b1;
      else if (rdFrom(wtt_pkg::OFF_FCT0))
         match0_q <= 1'b0;
   end

   // comparator 1 sticky flag, same clear rule
   always_ff @(posedge core_clk) begin
      if (rst)
         match1_q <= 1'b0;
      else if (hit1)
         match1_q <= 1'b1;
      else if (rdFrom(wtt_pkg::OFF_FCT1))
         match1_q <= 1'b0;
   end

   // comparator 0 keeps action, data enable and link select
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fn0_q     <= wtt_pkg::FN_OFF;
         dvMatch_q <= 1'b0;
         dvAddr_q  <= 1'b0;
      end else if (wrTo(wtt_pkg::OFF_FCT0)) begin
         fn0_q     <= pwdata[3:0];
         dvMatch_q <= pwdata[wtt_pkg::DVMATCH_BIT];
         dvAddr_q  <= pwdata[wtt_pkg::DVADDR_BIT];
      end
   end

   // comparator 1 keeps only its action field
   // its data enable, link and size bits are dropped on write
   always_ff @(posedge core_clk) begin
      if (rst)
         fn1_q <= wtt_pkg::FN_OFF;
      else if (wrTo(wtt_pkg::OFF_FCT1))
         fn1_q <= pwdata[3:0];
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         act0_q <= 1'b0;
         act1_q <= 1'b0;
      end else if (wrTo(wtt_pkg::OFF_TBCTRL)) begin
         act0_q <= pwdata[0];
         act1_q <= pwdata[1];
      end
   end

   // interrupt enable, same layout as status
   always_ff @(posedge core_clk) begin
      if (rst)
         irqEn_q <= 4'h0;
      else if (wrTo(wtt_pkg::OFF_IRQEN))
         irqEn_q <= pwdata[3:0];
   end

   // requests fire only when a flag rises, so a flag left set
   // by an unread match does not repeat its request
   assign rise0 = hit0 & ~match0_q;
   assign rise1 = hit1 & ~match1_q;

   assign req0Start = rise0 & act0_q;
   assign req0Stop  = rise0 & ~act0_q;

   assign req1Start = rise1 & act1_q;
   assign req1Stop  = rise1 & ~act1_q;

   // both may rise together; the recorder gives start priority
   assign start_d = req0Start | req1Start;
   assign stop_d  = req0Stop | req1Stop;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         traceStartPulse <= 1'b0;
         traceStopPulse  <= 1'b0;
      end else begin
         traceStartPulse <= start_d;
         traceStopPulse  <= stop_d;
      end
   end

   // recorder state: gated, start first
   always_ff @(posedge core_clk) begin
      if (rst)
         recording_q <= 1'b0;
      else if (traceStartPulse && startTriggerEnable)
         recording_q <= 1'b1;
      else if (traceStopPulse && stopTriggerEnable)
         recording_q <= 1'b0;
   end
   always_ff @(posedge core_clk) begin
      if (rst) traceRecording <= 1'b0;
      else     traceRecording <= recording_q;
   end

   // irq events: match0, match1, start, stop
   assign irqSet = {stop_d, start_d, hit1, hit0};

   // write-one-to-clear; an event in the same cycle keeps its bit
   assign irqClr = wrTo(wtt_pkg::OFF_IRQCLR) ? pwdata[3:0] : 4'h0;

   always_ff @(posedge core_clk) begin
      if (rst)
         irqStat_q <= 4'h0;
      else
         irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
   end
   always_ff @(posedge core_clk) begin
      if (rst) irq <= 1'b0;
      else     irq <= |(irqStat_q & irqEn_q);
   end

   // read word built from the current state; a hit of this cycle is
   // folded into the flag so the clear that follows cannot lose it
   always_comb begin
      rdWord = wtt_pkg::ZERO_WORD;
      rdErr  = 1'b0;
      case (paddr)
         wtt_pkg::OFF_FCT0: begin
            rdWord[3:0]                  = fn0_q;
            rdWord[wtt_pkg::DVMATCH_BIT] = dvMatch_q;
            rdWord[wtt_pkg::DVADDR_BIT]  = dvAddr_q;
            rdWord[wtt_pkg::MATCH_BIT]   = match0_q | hit0;
         end
         wtt_pkg::OFF_FCT1: begin
            rdWord[3:0]                = fn1_q;
            rdWord[wtt_pkg::MATCH_BIT] = match1_q | hit1;
         end
         wtt_pkg::OFF_TBCTRL: begin
            rdWord[wtt_pkg::CNT_LSB+:4] = wtt_pkg::NUM_COMP;
            rdWord[1:0]                 = {act1_q, act0_q};
         end
         wtt_pkg::OFF_CMP0: begin
            rdWord[0] = recording_q;
         end
         wtt_pkg::OFF_IRQSTAT: begin
            rdWord[3:0] = irqStat_q;
         end
         wtt_pkg::OFF_IRQEN: begin
            rdWord[3:0] = irqEn_q;
         end
         // write-only clear register reads zero
         wtt_pkg::OFF_IRQCLR: begin
            rdWord = wtt_pkg::ZERO_WORD;
         end
         default: begin
            rdErr = 1'b1;
         end
      endcase
   end

   // read data registered in setup; answer in access phase, no waits
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata  <= wtt_pkg::ZERO_WORD;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & rdErr;
         prdata  <= setup ? rdWord : wtt_pkg::ZERO_WORD;
      end
   end
endmodule : wtt_trigger

/* File: tb/wtt_trigger_props.sv */
// port checker for the watchpoint trace trigger
// assumes one core_clk domain and a synchronous active-high rst
module wtt_trigger_props (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        addrHit0,
   input wire logic        dataHit0,
   input wire logic        addrHit1,
   input wire logic        startTriggerEnable,
   input wire logic        traceStartPulse,
   input wire logic        traceStopPulse,
   input wire logic        traceRecording
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic rdAcc = pready && !pwrite;
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   error_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
   count_read_a: assert property (
      rdAcc && paddr == wtt_pkg::OFF_TBCTRL |-> prdata[31:2] == {wtt_pkg::NUM_COMP, 26'h0})
      else $error("control read wrong");
   fct1_zero_a: assert property (
      rdAcc && paddr == wtt_pkg::OFF_FCT1 |-> (prdata & 32'hfeff_fff0) == 32'h0)
      else $error("function read wrong");
   start_rec_a: assert property (
      traceStartPulse && startTriggerEnable |-> ##[1:2] traceRecording) else $error("no record");
   start_cause_a: assert property (
      traceStartPulse |-> $past(addrHit0 || dataHit0 || addrHit1)) else $error("stray start");
   stop_cause_a: assert property (
      traceStopPulse |-> $past(addrHit0 || dataHit0 || addrHit1)) else $error("stray stop");
endmodule : wtt_trigger_props
bind wtt_trigger wtt_trigger_props i_wtt_trigger_props (.*);

/* File: tb/wtt_recorder_model.sv */
// behavioural trace recorder driven by the trigger pulses
// assumes one-cycle pulses on core_clk
module wtt_recorder_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic traceStartPulse,
   input  wire logic traceStopPulse,
   input  wire logic startTriggerEnable,
   input  wire logic stopTriggerEnable,
   output logic      recording_q
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge core_clk) begin
      if (rst) recording_q <= 1'b0;
      else if (traceStartPulse && startTriggerEnable) recording_q <= 1'b1;
      else if (traceStopPulse && stopTriggerEnable) recording_q <= 1'b0;
   end
endmodule : wtt_recorder_model

/* File: tb/wtt_trigger_test.sv */
// self-checking bench for the watchpoint trace trigger
// assumes the checker is bound and the recorder model stands beside
module wtt_trigger_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic busFetch = 0, busRead = 0, busWrite = 0, addrHit0 = 0, dataHit0 = 0, addrHit1 = 0;
   logic startTriggerEnable = 0, stopTriggerEnable = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h0000_003b;
   logic pready, pslverr, traceStartPulse, traceStopPulse, traceRecording, irq, modelRec;
   logic [32:0] expQ[$];
   logic [3:0] codes[5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
   logic [5:0] modes[6] = '{6'b100001, 6'b010000, 6'b010011, 6'b010110, 6'b011111, 6'b101110};
   logic [4:0] trig[4] = '{5'b11111, 5'b00101, 5'b10010, 5'b01111};
   int failures = 0, checks = 0;
   wtt_trigger i_wtt_trigger (.*);
   wtt_recorder_model i_wtt_recorder_model (.core_clk, .rst, .traceStartPulse,
      .traceStopPulse, .startTriggerEnable, .stopTriggerEnable, .recording_q(modelRec));
   initial forever #25 core_clk = ~core_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic cmp(string n, logic [32:0] e, logic [32:0] s);
      checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic close_out();
      if (failures == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] e, logic er = 0);
      int n;
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      if (!w) expQ.push_back({er, e});
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
      {psel, penable} <= 2'b00;
      if (n == 20) begin failures++; close_out(); end
   endtask : xfer
   task automatic hit(logic [2:0] b, logic [2:0] h);
      @(posedge core_clk);
      {busFetch, busRead, busWrite, addrHit0, dataHit0, addrHit1} <= {b, h};
      @(posedge core_clk);
      {busFetch, busRead, busWrite, addrHit0, dataHit0, addrHit1} <= 6'h0;
   endtask : hit
   always @(posedge core_clk)
      if (pready === 1'b1 && pwrite === 1'b0) cmp("read", expQ.pop_front(), {pslverr, prdata});
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         r = rnd();
         xfer(1, wtt_pkg::OFF_FCT1, (r & 32'hffff_fff0) | codes[i], 0);
         xfer(0, wtt_pkg::OFF_FCT1, 0, {28'h0, codes[i]});
      end
      hit(3'b100, 3'b001);
      hit(3'b010, 3'b001);
      xfer(0, wtt_pkg::OFF_FCT1, 0, 32'h0100_0007);
      xfer(0, wtt_pkg::OFF_FCT1, 0, 32'h0000_0007);
      xfer(1, wtt_pkg::OFF_FCT1, 0, 0);
      for (int i = 0; i < 6; i++) begin
         xfer(1, wtt_pkg::OFF_FCT0, {19'h0, modes[i][2], 3'h0, modes[i][1], 8'h7}, 0);
         hit(3'b001, modes[i][5:3]);
         xfer(0, wtt_pkg::OFF_FCT0, 0,
              {7'h0, modes[i][0], 11'h0, modes[i][2], 3'h0, modes[i][1], 8'h7});
      end
      xfer(1, wtt_pkg::OFF_FCT0, 32'h5, 0);
      xfer(1, wtt_pkg::OFF_FCT1, 32'h5, 0);
      foreach (trig[i]) begin
         {startTriggerEnable, stopTriggerEnable} <= trig[i][2:1];
         xfer(1, wtt_pkg::OFF_TBCTRL, {rnd() & 32'h0fff_fffc} | trig[i][4:3], 0);
         xfer(0, wtt_pkg::OFF_TBCTRL, 0, {wtt_pkg::NUM_COMP, 26'h0, trig[i][4:3]});
         hit(3'b010, 3'b101);
         repeat (4) @(posedge core_clk);
         cmp("recording", {32'h0, trig[i][0]}, {32'h0, traceRecording});
         cmp("model", {32'h0, trig[i][0]}, {32'h0, modelRec});
         xfer(0, wtt_pkg::OFF_FCT0, 0, 32'h0100_0005);
         xfer(0, wtt_pkg::OFF_FCT1, 0, 32'h0100_0005);
      end
      xfer(0, wtt_pkg::OFF_IRQSTAT, 0, 32'hf);
      cmp("irq", 33'h0, {32'h0, irq});
      xfer(1, wtt_pkg::OFF_IRQEN, 32'h2, 0);
      repeat (2) @(posedge core_clk);
      cmp("irq", 33'h1, {32'h0, irq});
      xfer(1, wtt_pkg::OFF_IRQCLR, 32'h2, 0);
      repeat (2) @(posedge core_clk);
      cmp("irq", 33'h0, {32'h0, irq});
      xfer(0, wtt_pkg::OFF_IRQSTAT, 0, 32'hd);
      xfer(0, wtt_pkg::OFF_IRQCLR, 0, 32'h0);
      xfer(0, 12'h100, 0, 32'h0, 1'b1);
      repeat (2) @(posedge core_clk);
      close_out();
   end
endmodule : wtt_trigger_test
